// ==== include/cpc_pkg.sv ====
// constants, types and helpers for the four-channel protection control block
// assumes a 250 MHz system clock and one shared package for all design files
package cpc_pkg;

	localparam int CPC_NCH = 4;

	////////////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [4:0] CPC_ADDR_SWREQ = 5'h00;
	localparam logic [4:0] CPC_ADDR_CFG = 5'h04;
	localparam logic [4:0] CPC_ADDR_LIM0 = 5'h08;
	localparam logic [4:0] CPC_ADDR_STATUS = 5'h18;
	localparam logic [4:0] CPC_ADDR_CLEAR = 5'h1C;

	// field positions
	localparam int CPC_CFG_POLICY_BIT = 0;
	localparam int CPC_CFG_LATCH_BIT = 1;
	localparam int CPC_CFG_SCALE_LSB = 2;
	localparam int CPC_LIM_LEVEL_LSB = 0;
	localparam int CPC_LIM_WIN_LSB = 4;
	localparam int CPC_ST_DRIVE_LSB = 0;
	localparam int CPC_ST_FAULT_LSB = 4;
	localparam int CPC_ST_WIN_LSB = 8;
	localparam int CPC_ST_FLT_BIT = 12;
	localparam int CPC_ST_PIN_BIT = 13;

	// reset values
	localparam logic [3:0] CPC_SWREQ_RST = 4'h0;
	localparam logic [3:0] CPC_CFG_RST = 4'h0;
	localparam logic [7:0] CPC_LIM_RST = 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// timing
	localparam int CPC_CLK_PERIOD_NS = 4;
	localparam int CPC_MS_NS = 1000000;
	localparam int CPC_MS_CYCLES = CPC_MS_NS / CPC_CLK_PERIOD_NS;
	localparam int CPC_FAST_OFF_NS = 1000;
	localparam int CPC_FAST_OFF_CYCLES = (CPC_FAST_OFF_NS + CPC_CLK_PERIOD_NS - 1) / CPC_CLK_PERIOD_NS;
	localparam logic [7:0] CPC_RETRY_MS = 8'h01;

	// startup limit scale codes; fixed code means 2.2 A absolute
	localparam logic [1:0] CPC_SCALE_BASE = 2'h0;
	localparam logic [1:0] CPC_SCALE_DOUBLE = 2'h1;
	localparam logic [1:0] CPC_SCALE_HALF = 2'h2;
	localparam logic [1:0] CPC_SCALE_FIXED = 2'h3;
	localparam logic CPC_POLICY_BASE_REPORT = 1'h1;

	typedef enum logic [2:0] {
		CPC_OFF,
		CPC_ON,
		CPC_FAST_OFF,
		CPC_THERM_OFF,
		CPC_LATCHED
	} cpc_state_t;

	// comparator flags from the analog side of one channel
	typedef struct packed {
		logic at_limit;
		logic fast_trip;
		logic ot_abs;
		logic ot_rel;
		logic ot_cool;
	} cpc_sense_t;

	// limit selection handed to the analog regulator
	typedef struct packed {
		logic [3:0] level;
		logic [1:0] scale;
	} cpc_ilim_cmd_t;

	// startup window length in ms for a four-bit code
	function automatic logic [6:0] cpc_window_ms(input logic [3:0] code);
		case (code)
			4'h0: cpc_window_ms = 7'h00;
			4'h1: cpc_window_ms = 7'h02;
			4'h2: cpc_window_ms = 7'h04;
			4'h3: cpc_window_ms = 7'h06;
			4'h4: cpc_window_ms = 7'h08;
			4'h5: cpc_window_ms = 7'h0A;
			4'h6: cpc_window_ms = 7'h0C;
			4'h7: cpc_window_ms = 7'h10;
			4'h8: cpc_window_ms = 7'h14;
			4'h9: cpc_window_ms = 7'h18;
			4'hA: cpc_window_ms = 7'h1C;
			4'hB: cpc_window_ms = 7'h20;
			4'hC: cpc_window_ms = 7'h28;
			4'hD: cpc_window_ms = 7'h30;
			4'hE: cpc_window_ms = 7'h38;
			default: cpc_window_ms = 7'h40;
		endcase
	endfunction

	// byte address of the limit register of channel idx
	function automatic logic [4:0] cpc_lim_addr(input int idx);
		cpc_lim_addr = CPC_ADDR_LIM0 + 5'(idx * 4);
	endfunction

endpackage

// ==== src/cpc_sync.sv ====
// three-stage input synchroniser with agreement filter
// assumes asynchronous inputs; output changes only when stages two and three agree
`timescale 1ns/1ns
module cpc_sync #(
	parameter int W = 1
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;
	logic [W-1:0] filt_ff;
	logic [W-1:0] agree;
	logic [W-1:0] nxt_filt;

	// stage one feeds stage two only, so metastability never reaches logic
	assign agree = ~(s2_ff ^ s3_ff);
	assign nxt_filt = (agree & s3_ff) | (~agree & filt_ff);
	assign sync_out = filt_ff;

	// shift chain and filter
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
			filt_ff <= '0;
		end else begin
			s1_ff <= async_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			filt_ff <= nxt_filt;
		end
	end

endmodule

// ==== src/cpc_top.sv ====
// four-channel protection and output control with a plain register port
// assumes analog comparators and the gate pin are asynchronous; register port is on clk_sys
//
// Behaviour
// - policy one: base limit, faults reported in window
// - other policy: scaled limit, reports suppressed in window
// - scale codes: base, double, half, fixed 2.2A
// - overheating shuts only the affected channel
// - after cooling, latch off or retry per setting
// - gate low forces every channel off
// - requests stored while gated, followed afterwards
// - retry only after wait and faults cleared
// - thermal trip in window retries with startup limit
// - reaching regulation limit registers overcurrent fault
// - any reported fault asserts the fault pin
// - fast trip outside window: brief off, then regulate again
// - upper limit nibble selects window 0..64 ms
// - absolute fault clears on hysteresis, relative after wait
`timescale 1ns/1ns
module cpc_top
	import cpc_pkg::*;
#(
	parameter int MS_CYCLES = CPC_MS_CYCLES
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [4:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic global_output_gate,
	input wire cpc_sense_t [CPC_NCH-1:0] sense,
	input wire logic fault_flag_pin_i,
	output logic fault_flag_pin_o,
	output logic fault_flag_pin_oe,
	output logic [CPC_NCH-1:0] chan_drive,
	output cpc_ilim_cmd_t [CPC_NCH-1:0] ilim_cmd
);

	////////////////////////////////////////////////////////////////////////////////
	// input synchronisation

	logic [$bits(sense)+1:0] raw_in;
	logic [$bits(sense)+1:0] syn_in;
	cpc_sense_t [CPC_NCH-1:0] sense_s;
	logic gate_s;
	logic pin_s;

	// gate, pin readback and all comparator flags share one filter
	assign raw_in = {fault_flag_pin_i, global_output_gate, sense};
	assign sense_s = syn_in[$bits(sense)-1:0];
	assign gate_s = syn_in[$bits(sense)];
	assign pin_s = syn_in[$bits(sense)+1];

	cpc_sync #(
		.W($bits(sense) + 2)
	) u_sync (
		.clk_sys(clk_sys),
		.reset(reset),
		.async_in(raw_in),
		.sync_out(syn_in)
	);

	////////////////////////////////////////////////////////////////////////////////
	// millisecond tick shared by all window and retry timers

	logic [17:0] ms_cnt_ff;
	logic tick_ms;

	assign tick_ms = (ms_cnt_ff == 18'h00000);

	// free-running prescaler; a short MS_CYCLES speeds up simulation
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ms_cnt_ff <= 18'h00000;
		end else if (tick_ms) begin
			ms_cnt_ff <= 18'(MS_CYCLES - 1);
		end else begin
			ms_cnt_ff <= ms_cnt_ff - 18'h00001;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register file

	logic [3:0] swreq_ff;
	logic [3:0] cfg_ff;
	logic [CPC_NCH-1:0][7:0] lim_ff;
	logic [31:0] rdata_ff;
	logic wr_swreq;
	logic wr_cfg;
	logic wr_clear;
	logic [CPC_NCH-1:0] wr_lim;
	logic [CPC_NCH-1:0] clear_latch;
	logic [CPC_NCH-1:0] eff_req;
	logic [CPC_NCH-1:0] ch_fault;
	logic [CPC_NCH-1:0] ch_report;
	logic [CPC_NCH-1:0] ch_window;
	logic fault_flag_ff;
	logic [31:0] status_word;
	logic [31:0] nxt_rdata;
	logic [31:0] lim_rd;

	// write decode
	assign wr_swreq = reg_wr & (reg_addr == CPC_ADDR_SWREQ);
	assign wr_cfg = reg_wr & (reg_addr == CPC_ADDR_CFG);
	assign wr_clear = reg_wr & (reg_addr == CPC_ADDR_CLEAR);
	// write one to release a latched-off channel
	assign clear_latch = wr_clear ? reg_wdata[CPC_NCH-1:0] : 4'h0;

	// requests are always stored; the gate only masks their effect
	assign eff_req = swreq_ff & {CPC_NCH{gate_s}};

	// software-visible state of the channels
	assign status_word = {18'h00000, pin_s, fault_flag_ff, ch_window, ch_fault, chan_drive};

	// limit readback, zero when no limit register is addressed
	always_comb begin
		lim_rd = 32'h00000000;
		for (int i = 0; i < CPC_NCH; i++) begin
			if (reg_addr == cpc_lim_addr(i)) begin
				lim_rd = {24'h000000, lim_ff[i]};
			end
		end
	end

	// read select; unmapped addresses answer zero
	assign nxt_rdata = !reg_rd ? 32'h00000000 :
		(reg_addr == CPC_ADDR_SWREQ) ? {28'h0000000, swreq_ff} :
		(reg_addr == CPC_ADDR_CFG) ? {28'h0000000, cfg_ff} :
		(reg_addr == CPC_ADDR_STATUS) ? status_word :
		lim_rd;
	assign reg_rdata = rdata_ff;

	// control registers
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			swreq_ff <= CPC_SWREQ_RST;
			cfg_ff <= CPC_CFG_RST;
			rdata_ff <= 32'h00000000;
		end else begin
			if (wr_swreq) begin
				swreq_ff <= reg_wdata[3:0];
			end
			if (wr_cfg) begin
				cfg_ff <= reg_wdata[3:0];
			end
			rdata_ff <= nxt_rdata;
		end
	end

	// per-channel limit registers; level in low nibble, window code above
	for (genvar g = 0; g < CPC_NCH; g++) begin : g_lim
		assign wr_lim[g] = reg_wr & (reg_addr == cpc_lim_addr(g));
		always_ff @(posedge clk_sys) begin
			if (reset) begin
				lim_ff[g] <= CPC_LIM_RST;
			end else if (wr_lim[g]) begin
				lim_ff[g] <= reg_wdata[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// fault pin: open drain, pulled low while any channel reports

	assign fault_flag_pin_o = 1'h0;
	assign fault_flag_pin_oe = fault_flag_ff;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			fault_flag_ff <= 1'h0;
		end else begin
			fault_flag_ff <= |ch_report;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// channel controllers, one independent copy each

	for (genvar c = 0; c < CPC_NCH; c++) begin : g_ch
		cpc_state_t state_ff;
		cpc_state_t nxt_state;
		logic [6:0] win_cnt_ff;
		logic [6:0] nxt_win;
		logic [7:0] retry_cnt_ff;
		logic [7:0] fast_cnt_ff;
		logic oc_fault_ff;
		logic abs_pend_ff;
		logic rel_pend_ff;
		logic win_therm_ff;
		logic drive_ff;
		cpc_ilim_cmd_t cmd_ff;
		logic in_window;
		logic therm_hit;
		logic running;
		logic enter_therm;
		logic retry_ok;
		logic start_win;
		logic policy_base;
		logic [1:0] scale_sel;

		assign in_window = (win_cnt_ff != 7'h00);
		assign therm_hit = sense_s[c].ot_abs | sense_s[c].ot_rel;
		assign running = (state_ff == CPC_ON) | (state_ff == CPC_FAST_OFF);
		assign enter_therm = running & therm_hit;
		// all faults gone and wait expired before a channel may come back
		assign retry_ok = (state_ff == CPC_THERM_OFF) & (retry_cnt_ff == 8'h00)
			& ~abs_pend_ff & ~rel_pend_ff & ~oc_fault_ff & ~therm_hit;
		// window opens on off-to-on, or again when a window trip retries
		assign start_win = ((state_ff == CPC_OFF) & eff_req[c])
			| (retry_ok & ~cfg_ff[CPC_CFG_LATCH_BIT] & eff_req[c] & win_therm_ff);
		assign policy_base = (cfg_ff[CPC_CFG_POLICY_BIT] == CPC_POLICY_BASE_REPORT);
		assign scale_sel = (in_window & ~policy_base) ?
			cfg_ff[CPC_CFG_SCALE_LSB+:2] : CPC_SCALE_BASE;

		// window counter runs only while the channel conducts
		assign nxt_win = start_win ? cpc_window_ms(lim_ff[c][CPC_LIM_WIN_LSB+:4]) :
			!running ? 7'h00 :
			(tick_ms & in_window) ? win_cnt_ff - 7'h01 : win_cnt_ff;

		// next-state logic
		always_comb begin
			nxt_state = state_ff;
			case (state_ff)
				CPC_OFF: begin
					if (eff_req[c]) begin
						nxt_state = CPC_ON;
					end
				end
				CPC_ON: begin
					if (therm_hit) begin
						nxt_state = CPC_THERM_OFF;
					end else if (!eff_req[c]) begin
						nxt_state = CPC_OFF;
					end else if (sense_s[c].fast_trip & ~in_window) begin
						nxt_state = CPC_FAST_OFF;
					end
				end
				CPC_FAST_OFF: begin
					if (therm_hit) begin
						nxt_state = CPC_THERM_OFF;
					end else if (!eff_req[c]) begin
						nxt_state = CPC_OFF;
					end else if (fast_cnt_ff == 8'h00) begin
						nxt_state = CPC_ON;
					end
				end
				CPC_THERM_OFF: begin
					if (retry_ok) begin
						if (cfg_ff[CPC_CFG_LATCH_BIT]) begin
							nxt_state = CPC_LATCHED;
						end else begin
							nxt_state = eff_req[c] ? CPC_ON : CPC_OFF;
						end
					end
				end
				CPC_LATCHED: begin
					if (clear_latch[c]) begin
						nxt_state = CPC_OFF;
					end
				end
				default: begin
					nxt_state = CPC_OFF;
				end
			endcase
		end

		// state and timers; every channel owns its copies
		always_ff @(posedge clk_sys) begin
			if (reset) begin
				state_ff <= CPC_OFF;
				win_cnt_ff <= 7'h00;
				retry_cnt_ff <= 8'h00;
				fast_cnt_ff <= 8'h00;
			end else begin
				state_ff <= nxt_state;
				win_cnt_ff <= nxt_win;
				if (enter_therm) begin
					retry_cnt_ff <= CPC_RETRY_MS;
				end else if (tick_ms & (retry_cnt_ff != 8'h00)) begin
					retry_cnt_ff <= retry_cnt_ff - 8'h01;
				end
				if (state_ff != CPC_FAST_OFF) begin
					fast_cnt_ff <= 8'(CPC_FAST_OFF_CYCLES - 1);
				end else if (fast_cnt_ff != 8'h00) begin
					fast_cnt_ff <= fast_cnt_ff - 8'h01;
				end
			end
		end

		// fault bookkeeping; a new cause always beats its clear
		always_ff @(posedge clk_sys) begin
			if (reset) begin
				oc_fault_ff <= 1'h0;
				abs_pend_ff <= 1'h0;
				rel_pend_ff <= 1'h0;
				win_therm_ff <= 1'h0;
			end else begin
				oc_fault_ff <= (running & (sense_s[c].at_limit | sense_s[c].fast_trip))
					| (state_ff == CPC_FAST_OFF);
				abs_pend_ff <= (enter_therm & sense_s[c].ot_abs) | (abs_pend_ff & ~sense_s[c].ot_cool);
				rel_pend_ff <= (enter_therm & sense_s[c].ot_rel)
					| (rel_pend_ff & ~(retry_cnt_ff == 8'h00));
				if (enter_therm) begin
					win_therm_ff <= in_window;
				end else if (state_ff != CPC_THERM_OFF) begin
					win_therm_ff <= 1'h0;
				end
			end
		end

		// registered drive and limit selection toward the power stage
		always_ff @(posedge clk_sys) begin
			if (reset) begin
				drive_ff <= 1'h0;
				cmd_ff <= '0;
			end else begin
				drive_ff <= (nxt_state == CPC_ON) & eff_req[c];
				cmd_ff.level <= lim_ff[c][CPC_LIM_LEVEL_LSB+:4];
				cmd_ff.scale <= scale_sel;
			end
		end

		assign chan_drive[c] = drive_ff;
		assign ilim_cmd[c] = cmd_ff;
		assign ch_window[c] = in_window;
		assign ch_fault[c] = oc_fault_ff | (state_ff == CPC_THERM_OFF) | (state_ff == CPC_LATCHED);
		// the startup policy may hide faults while the window is open
		assign ch_report[c] = ch_fault[c] & ~(in_window & ~policy_base);
	end

endmodule

// ==== verif/cpc_top_assertions.sv ====
// concurrent checks on the ports of the protection control top
// assumes one clock domain and a bind from the bench top file
`timescale 1ns/1ns
module cpc_top_assertions
	import cpc_pkg::*;
#(
	parameter int MS_CYCLES = CPC_MS_CYCLES
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [4:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic global_output_gate,
	input wire cpc_sense_t [CPC_NCH-1:0] sense,
	input wire logic fault_flag_pin_o,
	input wire logic fault_flag_pin_oe,
	input wire logic [CPC_NCH-1:0] chan_drive
);
	logic [3:0] swreq_sh_ff;
	logic [3:0] cfg_sh_ff;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	////////////////////////////////////////////////////////////////////////////////
	// shadows of the writable control words, for readback checks
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			swreq_sh_ff <= CPC_SWREQ_RST;
			cfg_sh_ff <= CPC_CFG_RST;
		end else begin
			if (reg_wr && reg_addr == CPC_ADDR_SWREQ) begin
				swreq_sh_ff <= reg_wdata[3:0];
			end
			if (reg_wr && reg_addr == CPC_ADDR_CFG) begin
				cfg_sh_ff <= reg_wdata[3:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// gate must be low long enough to pass the synchroniser
	sequence s_gate_low;
		!global_output_gate [*8];
	endsequence
	sequence s_read(logic [4:0] a);
		reg_rd && reg_addr == a;
	endsequence
	property p_hot_off(logic hot, logic drv);
		hot [*8] |=> !drv;
	endproperty

	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data not zero outside read cycle");
	a_pin_o_low: assert property (fault_flag_pin_o == 1'b0)
		else $error("fault pin output not low");
	a_gate_off: assert property (s_gate_low |=> chan_drive == 4'h0)
		else $error("channel driven while gate low");
	a_swreq_readback: assert property (s_read(CPC_ADDR_SWREQ) |=> reg_rdata == {28'h0, swreq_sh_ff})
		else $error("switch request readback wrong");
	a_cfg_readback: assert property (s_read(CPC_ADDR_CFG) |=> reg_rdata == {28'h0, cfg_sh_ff})
		else $error("config readback wrong");
	a_unmapped_zero: assert property (reg_rd && reg_addr[1:0] != 2'h0 |=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	a_status_mirror: assert property (s_read(CPC_ADDR_STATUS) |=>
		reg_rdata[3:0] == $past(chan_drive) && reg_rdata[12] == $past(fault_flag_pin_oe))
		else $error("status does not mirror pins");

	// thermal trips are per channel
	for (genvar c = 0; c < CPC_NCH; c++) begin : g_ch
		a_ot_abs_off: assert property (p_hot_off(sense[c].ot_abs, chan_drive[c]))
			else $error("channel on above absolute temperature");
		a_ot_rel_off: assert property (p_hot_off(sense[c].ot_rel, chan_drive[c]))
			else $error("channel on above relative temperature");
	end
endmodule

// ==== verif/cpc_analog_model.sv ====
// analog side model: comparator flags of four channels and the fault wire
// assumes the bench commands load faults and heating per channel
`timescale 1ns/1ns
module cpc_analog_model
	import cpc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic [CPC_NCH-1:0] chan_drive,
	input wire logic [CPC_NCH-1:0] overload,
	input wire logic [CPC_NCH-1:0] short_fast,
	input wire logic [CPC_NCH-1:0] hot_abs,
	input wire logic [CPC_NCH-1:0] hot_rel,
	input wire logic fault_flag_pin_o,
	input wire logic fault_flag_pin_oe,
	output cpc_sense_t [CPC_NCH-1:0] sense,
	output logic fault_wire
);
	initial sense = '0;

	// current flags need a conducting channel; temperature follows the die
	always @(posedge clk_sys) begin
		for (int c = 0; c < CPC_NCH; c++) begin
			sense[c].at_limit <= chan_drive[c] & overload[c];
			sense[c].fast_trip <= chan_drive[c] & short_fast[c];
			sense[c].ot_abs <= hot_abs[c];
			sense[c].ot_rel <= hot_rel[c];
			sense[c].ot_cool <= ~hot_abs[c];
		end
	end

	// open-drain wire with pull-up, never left unknown
	assign fault_wire = fault_flag_pin_oe ? fault_flag_pin_o : 1'b1;
endmodule

// ==== verif/cpc_top_test.sv ====
// self-checking bench for the protection control block
// assumes the analog model as far side and the checker bound to cpc_top
`timescale 1ns/1ns
module cpc_top_test
	import cpc_pkg::*;
;
	localparam int MS = 10;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic [4:0] reg_addr = 5'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic [31:0] reg_rdata;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic gate = 1'b0;
	cpc_sense_t [CPC_NCH-1:0] sense;
	cpc_ilim_cmd_t [CPC_NCH-1:0] ilim;
	logic [3:0] drive;
	logic [3:0] overload = 4'h0;
	logic [3:0] short_fast = 4'h0;
	logic [3:0] hot_abs = 4'h0;
	logic [3:0] hot_rel = 4'h0;
	logic pin_o;
	logic pin_oe;
	logic wire_lvl;
	logic [31:0] d;
	int errors = 0;
	int n_tests = 0;
	int cycles = 0;

	always #2 clk_sys = ~clk_sys;

	cpc_top #(.MS_CYCLES(MS)) dut (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.global_output_gate(gate), .sense(sense), .fault_flag_pin_i(wire_lvl), .fault_flag_pin_o(pin_o),
		.fault_flag_pin_oe(pin_oe), .chan_drive(drive), .ilim_cmd(ilim));
	cpc_analog_model u_ana (.clk_sys(clk_sys), .chan_drive(drive), .overload(overload),
		.short_fast(short_fast), .hot_abs(hot_abs), .hot_rel(hot_rel), .fault_flag_pin_o(pin_o),
		.fault_flag_pin_oe(pin_oe), .sense(sense), .fault_wire(wire_lvl));

	////////////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [4:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [4:0] a);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	// heat the masked channels, cool them, expect the given drive afterwards
	task automatic trip(input logic [3:0] a, input logic [3:0] r, input logic [3:0] back);
		@(posedge clk_sys);
		hot_abs <= a;
		hot_rel <= r;
		wait_cyc(20);
		chk({28'h0, drive}, {28'h0, ~(a | r)}, "thermal off");
		@(posedge clk_sys);
		hot_abs <= 4'h0;
		hot_rel <= 4'h0;
		wait_cyc(40);
		chk({28'h0, drive}, {28'h0, back}, "after cooling");
	endtask

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// hang guard, far above the expected run length
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			conclude();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			rd(CPC_ADDR_LIM0 + 5'(4 * i));
			chk(d, 32'h0, "limit reset");
			wr(CPC_ADDR_LIM0 + 5'(4 * i), 32'hFFFF_FF0C + 32'(i));
			rd(CPC_ADDR_LIM0 + 5'(4 * i));
			chk(d, 32'h0000_000C + 32'(i), "limit rw");
		end
		wr(CPC_ADDR_CFG, 32'hFFFF_FFFD);
		rd(CPC_ADDR_CFG);
		chk(d, 32'h0000_000D, "cfg rw");
		rd(5'h02);
		chk(d, 32'h0, "unmapped");
		wr(CPC_ADDR_STATUS, 32'hFFFF_FFFF);
		rd(CPC_ADDR_STATUS);
		chk(d, 32'h0000_2000, "status idle");
		$display("test registers done");

		// gate low: requests stored, outputs held off
		wr(CPC_ADDR_SWREQ, 32'hF);
		wait_cyc(20);
		chk({28'h0, drive}, 32'h0, "gated drive");
		rd(CPC_ADDR_SWREQ);
		chk(d, 32'hF, "stored request");
		@(posedge clk_sys);
		gate <= 1'b1;
		wait_cyc(20);
		chk({28'h0, drive}, 32'hF, "ungated drive");
		// drop the gate with channels on, then change requests while gated
		@(posedge clk_sys);
		gate <= 1'b0;
		wait_cyc(20);
		chk({28'h0, drive}, 32'h0, "gate dropped");
		wr(CPC_ADDR_SWREQ, 32'h5);
		@(posedge clk_sys);
		gate <= 1'b1;
		wait_cyc(20);
		chk({28'h0, drive}, 32'h5, "stored while gated");
		wr(CPC_ADDR_SWREQ, 32'hF);
		wait_cyc(4);
		$display("test gate done");

		trip(4'h2, 4'h0, 4'hF);
		trip(4'h0, 4'h1, 4'hF);
		wr(CPC_ADDR_CFG, 32'h2);
		trip(4'h4, 4'h0, 4'hB);
		wr(CPC_ADDR_CLEAR, 32'h4);
		wait_cyc(10);
		chk({28'h0, drive}, 32'hF, "latch released");
		$display("test thermal done");

		wr(CPC_ADDR_CFG, 32'h0);
		@(posedge clk_sys);
		overload <= 4'h1;
		wait_cyc(12);
		chk({31'h0, wire_lvl}, 32'h0, "overcurrent pin");
		rd(CPC_ADDR_STATUS);
		chk({28'h0, d[7:4]}, 32'h1, "overcurrent status");
		@(posedge clk_sys);
		overload <= 4'h0;
		short_fast <= 4'h8;
		wait_cyc(12);
		chk({28'h0, drive}, 32'h7, "fast trip off");
		@(posedge clk_sys);
		short_fast <= 4'h0;
		wait_cyc(260);
		chk({28'h0, drive}, 32'hF, "fast trip back");
		chk({31'h0, wire_lvl}, 32'h1, "pin released");
		$display("test faults done");

		// startup window: four-ms window code, level five, each scale code
		wr(CPC_ADDR_LIM0, 32'h25);
		for (int s = 0; s < 5; s++) begin
			wr(CPC_ADDR_CFG, (s < 4) ? 32'(s << 2) : 32'hD);
			wr(CPC_ADDR_SWREQ, 32'hE);
			@(posedge clk_sys);
			overload <= 4'h1;
			wr(CPC_ADDR_SWREQ, 32'hF);
			wait_cyc(12);
			chk({26'h0, ilim[0]}, {26'h0, 4'h5, (s < 4) ? 2'(s) : 2'h0}, "startup limit");
			chk({31'h0, wire_lvl}, (s < 4) ? 32'h1 : 32'h0, "report in window");
			wait_cyc(60);
			chk({26'h0, ilim[0]}, {26'h0, 4'h5, 2'h0}, "base after window");
			chk({31'h0, wire_lvl}, 32'h0, "report after window");
			@(posedge clk_sys);
			overload <= 4'h0;
		end
		// thermal trip inside the window: the retry opens the window again
		wr(CPC_ADDR_CFG, 32'h4);
		wr(CPC_ADDR_SWREQ, 32'hE);
		wr(CPC_ADDR_SWREQ, 32'hF);
		@(posedge clk_sys);
		hot_rel <= 4'h1;
		wait_cyc(4);
		@(posedge clk_sys);
		hot_rel <= 4'h0;
		wait_cyc(30);
		chk({28'h0, drive}, 32'hF, "window trip retried");
		chk({26'h0, ilim[0]}, {26'h0, 4'h5, 2'h1}, "retry startup limit");
		$display("test window done");
		conclude();
	end
endmodule

bind cpc_top cpc_top_assertions #(.MS_CYCLES(MS_CYCLES)) u_chk (.clk_sys(clk_sys), .reset(reset),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.global_output_gate(global_output_gate), .sense(sense), .fault_flag_pin_o(fault_flag_pin_o),
	.fault_flag_pin_oe(fault_flag_pin_oe), .chan_drive(chan_drive));
